/* touch_key_pkg.sv */
// Register map, field layout, bus addresses and timing of the touch key I2C slave
package touch_key_pkg;

   // Register offsets
   localparam logic [7:0] REG_FIRST_SENS  = 8'h00;
   localparam logic [7:0] REG_COMMON_SENS = 8'h01;
   localparam logic [7:0] REG_IDLE_CTRL   = 8'h02;
   localparam logic [7:0] REG_KEY_LOW     = 8'h08;
   localparam logic [7:0] REG_KEY_HIGH    = 8'h09;

   // Reset values and the read value of unmapped places
   localparam logic [7:0] SENS_RESET = 8'h79;
   localparam logic [7:0] CTRL_RESET = 8'h83;
   localparam logic [7:0] PTR_RESET  = 8'h08;
   localparam logic [7:0] READ_ZERO  = 8'h00;

   // Fields of the idle control register
   localparam int INTV_HI    = 7;
   localparam int INTV_LO    = 5;
   localparam int IMM_BIT    = 4;
   localparam int FREEZE_BIT = 3;
   localparam int FLAG_BIT   = 2;
   localparam int FIELD_HI   = 1;
   localparam int FIELD_LO   = 0;

   // Seven-bit slave addresses by select pin level
   localparam logic [6:0] ADDR_PIN_HIGH  = 7'h44;
   localparam logic [6:0] ADDR_PIN_FLOAT = 7'h40;
   localparam logic [6:0] ADDR_PIN_LOW   = 7'h42;

   // Byte and key geometry
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int         NUM_KEYS      = 12;
   localparam int         KEYS_LOW      = 8;
   localparam int         KEYS_HIGH     = 4;

   // Timing, as printed, and derived cycle counts
   localparam longint unsigned CLK_HZ            = 64'd50_000_000;
   localparam longint unsigned IDLE_ENTRY_S      = 64'd75;
   localparam longint unsigned IDLE_BASE_MS      = 64'd120;
   localparam longint unsigned ACTIVE_SAMPLE_MS  = 64'd13;
   localparam longint unsigned IDLE_ENTRY_CYC    = IDLE_ENTRY_S * CLK_HZ;
   localparam longint unsigned HALF_BASE_CYC     = IDLE_BASE_MS * CLK_HZ / 64'd2000;
   localparam longint unsigned ACTIVE_SAMPLE_CYC = ACTIVE_SAMPLE_MS * CLK_HZ / 64'd1000;

endpackage : touch_key_pkg

/* touch_idle_ctrl.sv */
// Idle entry and sampling interval timer of the touch key core
`timescale 1ns/10ps
module touch_idle_ctrl #(
   parameter int unsigned NOKEY_CYC  = 32'd3_750_000_000,
   parameter int unsigned HALF_CYC   = 32'd3_000_000,
   parameter int unsigned ACTIVE_CYC = 32'd650_000
) (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   // Control
   input  wire logic       any_key_i,
   input  wire logic [2:0] interval_i,
   input  wire logic       immediate_i,
   // Status
   output logic            idle_o,
   output logic            sample_tick_o
);

   logic [31:0] nokey_cnt_q;
   logic [31:0] unit_cnt_q;
   logic [3:0]  half_cnt_q;
   logic        idle_q;
   logic        tick_q;

   wire       nokey_done = nokey_cnt_q == 32'(NOKEY_CYC - 1);
   wire       enter_idle = !idle_q && !any_key_i && (immediate_i || nokey_done);
   wire       leave_idle = idle_q && any_key_i;
   wire       mode_chg   = enter_idle || leave_idle;
   wire [3:0] halves     = {interval_i, 1'b0} - 4'h1;
   wire       unit_end   = unit_cnt_q == (idle_q ? 32'(HALF_CYC - 1) : 32'(ACTIVE_CYC - 1));
   wire       period_end = unit_end && (!idle_q || half_cnt_q == halves - 4'h1);
   wire       stopped    = idle_q && interval_i == 3'h0;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         nokey_cnt_q <= 32'h0;
         idle_q      <= 1'b0;
      end else begin
         nokey_cnt_q <= (any_key_i || idle_q || nokey_done) ? 32'h0 : nokey_cnt_q + 32'h1;
         idle_q      <= enter_idle ? 1'b1 : (leave_idle ? 1'b0 : idle_q);
      end
   end

   // Interval is (2n-1) half base periods in idle
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         unit_cnt_q <= 32'h0;
         half_cnt_q <= 4'h0;
         tick_q     <= 1'b0;
      end else begin
         unit_cnt_q <= (mode_chg || unit_end) ? 32'h0 : unit_cnt_q + 32'h1;
         half_cnt_q <= (mode_chg || period_end) ? 4'h0 : half_cnt_q + {3'h0, unit_end};
         tick_q     <= period_end && !stopped && !mode_chg;
      end
   end

   assign idle_o        = idle_q;
   assign sample_tick_o = tick_q;

   AST_IMMEDIATE_IDLE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !idle_q && immediate_i && !any_key_i |=> idle_q)
      else $error("idle not entered at once with no key");

   AST_NO_TICK_CODE0: assert property (@(posedge core_clk_i) disable iff (rst_i)
      idle_q && interval_i == 3'h0 && $past(idle_q) && $past(interval_i) == 3'h0
      |-> !tick_q)
      else $error("sampling tick with interval code zero");

   CVR_IDLE_ENTRY: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(idle_q));

endmodule : touch_idle_ctrl

/* touch_key_i2c_slave_regs.sv */
// I2C slave and register file of a twelve-key capacitive touch controller
// Behaviour
// - Start is data falling while clock high; it begins every transfer.
// - Stop is data rising while clock high; it ends the transfer.
// - Data changes only while clock low, stable while clock high.
// - Every byte is eight data bits then one acknowledge bit.
// - Answer address 44H pin high, 40H floating, 42H low.
// - Second write byte loads the register pointer.
// - Third write byte is stored at the pointed register.
// - Further write bytes keep being accepted until a stop.
// - Every byte received while addressed is acknowledged.
// - Read bytes come from pointer onward, pointer increments per byte.
// - Pointer resets to 08H so a bare read returns key state.
// - Registers 00H and 01H hold sensitivities, write only, reset 79H.
// - Register 02H holds interval, immediate idle, freeze, flag, field; reset 83H.
// - Idle interval code 0 stops sampling, n gives (n-0.5) base periods.
// - Immediate bit enters idle at once with no key, else after 75 s.
// - Freeze bit stops automatic reference calibration.
// - Register 08H holds keys 0..7 from bit 7; 09H keys 8..11 in 7:4.
// - A key bit reads 0 while touched and 1 while untouched.
`timescale 1ns/10ps
module touch_key_i2c_slave_regs #(
   parameter int unsigned NOKEY_CYC  = 32'(touch_key_pkg::IDLE_ENTRY_CYC),
   parameter int unsigned HALF_CYC   = 32'(touch_key_pkg::HALF_BASE_CYC),
   parameter int unsigned ACTIVE_CYC = 32'(touch_key_pkg::ACTIVE_SAMPLE_CYC)
) (
   // Clocks and reset
   input  wire logic        core_clk_i,
   input  wire logic        link_clk_i,
   input  wire logic        rst_i,
   // I2C pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   // Address select pad
   input  wire logic        addr_select_pin_i,
   input  wire logic        addr_select_float_i,
   // Sensing front end
   input  wire logic [11:0] key_detect_i,
   output logic [7:0]       first_chan_sens_code_o,
   output logic [7:0]       common_sens_code_o,
   output logic [2:0]       idle_sample_interval_o,
   output logic             immediate_idle_o,
   output logic             cal_freeze_o,
   output logic             undoc_flag_b2_o,
   output logic [1:0]       undoc_field_b1_0_o,
   output logic             idle_o,
   output logic             sample_tick_o
);

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RX   = 5'b00010,
      ST_ACK  = 5'b00100,
      ST_TX   = 5'b01000,
      ST_RACK = 5'b10000
   } link_state_t;

   typedef enum logic [1:0] {
      IDX_ADDR = 2'h0,
      IDX_PTR  = 2'h1,
      IDX_DATA = 2'h2
   } byte_idx_t;

   // Read data mux: key bits inverted, channel 0 in bit 7
   function automatic logic [7:0] read_byte(input logic [7:0]  ptr,
                                            input logic [11:0] det);
      logic [7:0] r;
      r = touch_key_pkg::READ_ZERO;
      if (ptr == touch_key_pkg::REG_KEY_LOW) begin
         for (int i = 0; i < touch_key_pkg::KEYS_LOW; i++) begin
            r[7-i] = ~det[i];
         end
      end else if (ptr == touch_key_pkg::REG_KEY_HIGH) begin
         for (int i = 0; i < touch_key_pkg::KEYS_HIGH; i++) begin
            r[7-i] = ~det[touch_key_pkg::KEYS_LOW+i];
         end
      end
      return r;
   endfunction : read_byte

   // ---------------- Link domain ----------------
   logic        scl_s1, scl_s2, scl_s3;
   logic        sda_s1, sda_s2, sda_s3;
   logic        addr_select_pin_s1, addr_select_pin_s2;
   logic        afloat_s1, afloat_s2;
   logic [11:0] kdet_l_s1, kdet_l_s2;
   link_state_t st_q;
   byte_idx_t   idx_q;
   logic [3:0]  bit_cnt_q;
   logic [7:0]  sh_q;
   logic [7:0]  tx_q;
   logic [7:0]  ptr_q;
   logic        rd_q;
   logic        sda_oe_q;
   logic        sda_o_q;
   logic        wr_tgl_q;
   logic [7:0]  wr_addr_q;
   logic [7:0]  wr_data_q;

   always_ff @(posedge link_clk_i or posedge rst_i) begin
      if (rst_i) begin
         {scl_s1, scl_s2, scl_s3}       <= 3'h7;
         {sda_s1, sda_s2, sda_s3}       <= 3'h7;
         {addr_select_pin_s1, addr_select_pin_s2}             <= 2'h0;
         {afloat_s1, afloat_s2}         <= 2'h0;
         {kdet_l_s1, kdet_l_s2}         <= 24'h0;
         sda_o_q                        <= 1'b0;
      end else begin
         {scl_s1, scl_s2, scl_s3}       <= {scl_i, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3}       <= {sda_i, sda_s1, sda_s2};
         {addr_select_pin_s1, addr_select_pin_s2}             <= {addr_select_pin_i, addr_select_pin_s1};
         {afloat_s1, afloat_s2}         <= {addr_select_float_i, afloat_s1};
         {kdet_l_s1, kdet_l_s2}         <= {key_detect_i, kdet_l_s1};
         sda_o_q                        <= 1'b0;
      end
   end

   wire       scl_rise  = scl_s2 && !scl_s3;
   wire       scl_fall  = !scl_s2 && scl_s3;
   wire       start_det = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
   wire       stop_det  = scl_s2 && scl_s3 && sda_s2 && !sda_s3;
   wire [6:0] my_addr   = afloat_s2 ? touch_key_pkg::ADDR_PIN_FLOAT :
                          (addr_select_pin_s2 ? touch_key_pkg::ADDR_PIN_HIGH :
                                     touch_key_pkg::ADDR_PIN_LOW);
   wire       byte_end  = (st_q == ST_RX) && scl_fall &&
                          bit_cnt_q == touch_key_pkg::BITS_PER_BYTE;
   wire       addr_hit  = sh_q[7:1] == my_addr;
   wire [7:0] rd_byte   = read_byte(ptr_q, kdet_l_s2);

   always_ff @(posedge link_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q      <= ST_IDLE;
         idx_q     <= IDX_ADDR;
         bit_cnt_q <= 4'h0;
         sh_q      <= 8'h00;
         tx_q      <= 8'h00;
         ptr_q     <= touch_key_pkg::PTR_RESET;
         rd_q      <= 1'b0;
         sda_oe_q  <= 1'b0;
         wr_tgl_q  <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
      end else if (start_det) begin
         st_q      <= ST_RX;
         idx_q     <= IDX_ADDR;
         bit_cnt_q <= 4'h0;
         rd_q      <= 1'b0;
         sda_oe_q  <= 1'b0;
      end else if (stop_det) begin
         st_q      <= ST_IDLE;
         sda_oe_q  <= 1'b0;
      end else begin
         case (st_q)
            ST_RX: begin
               if (scl_rise) begin
                  sh_q      <= {sh_q[6:0], sda_s2};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (byte_end) begin
                  if (idx_q == IDX_ADDR && !addr_hit) begin
                     st_q <= ST_IDLE;
                  end else begin
                     st_q     <= ST_ACK;
                     sda_oe_q <= 1'b1;
                  end
                  if (idx_q == IDX_ADDR) begin
                     rd_q  <= sh_q[0];
                     idx_q <= IDX_PTR;
                  end
                  if (idx_q == IDX_PTR) begin
                     ptr_q <= sh_q;
                     idx_q <= IDX_DATA;
                  end
                  if (idx_q == IDX_DATA) begin
                     wr_addr_q <= ptr_q;
                     wr_data_q <= sh_q;
                     wr_tgl_q  <= ~wr_tgl_q;
                     ptr_q     <= ptr_q + 8'h01;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  bit_cnt_q <= 4'h0;
                  if (rd_q) begin
                     tx_q     <= rd_byte;
                     ptr_q    <= ptr_q + 8'h01;
                     sda_oe_q <= ~rd_byte[7];
                     st_q     <= ST_TX;
                  end else begin
                     sda_oe_q <= 1'b0;
                     st_q     <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_q == touch_key_pkg::BITS_PER_BYTE) begin
                     sda_oe_q <= 1'b0;
                     st_q     <= ST_RACK;
                  end else begin
                     tx_q     <= {tx_q[6:0], 1'b0};
                     sda_oe_q <= ~tx_q[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  st_q <= sda_s2 ? ST_IDLE : ST_ACK;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign sda_o    = sda_o_q;
   assign sda_oe_o = sda_oe_q;

   // ---------------- Core domain ----------------
   logic        tgl_s1, tgl_s2, tgl_s3;
   logic [11:0] kdet_c_s1, kdet_c_s2;
   logic [7:0]  first_sens_q;
   logic [7:0]  common_sens_q;
   logic [7:0]  ctrl_q;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         {tgl_s1, tgl_s2, tgl_s3} <= 3'h0;
         {kdet_c_s1, kdet_c_s2}   <= 24'h0;
      end else begin
         {tgl_s1, tgl_s2, tgl_s3} <= {wr_tgl_q, tgl_s1, tgl_s2};
         {kdet_c_s1, kdet_c_s2}   <= {key_detect_i, kdet_c_s1};
      end
   end

   // Address and data are held stable by the link until the next toggle
   wire wr_pulse  = tgl_s2 ^ tgl_s3;
   wire wr_first  = wr_pulse && wr_addr_q == touch_key_pkg::REG_FIRST_SENS;
   wire wr_common = wr_pulse && wr_addr_q == touch_key_pkg::REG_COMMON_SENS;
   wire wr_ctrl   = wr_pulse && wr_addr_q == touch_key_pkg::REG_IDLE_CTRL;
   wire any_key   = |kdet_c_s2;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         first_sens_q  <= touch_key_pkg::SENS_RESET;
         common_sens_q <= touch_key_pkg::SENS_RESET;
         ctrl_q        <= touch_key_pkg::CTRL_RESET;
      end else begin
         first_sens_q  <= wr_first ? wr_data_q : first_sens_q;
         common_sens_q <= wr_common ? wr_data_q : common_sens_q;
         ctrl_q        <= wr_ctrl ? wr_data_q : ctrl_q;
      end
   end

   assign first_chan_sens_code_o = first_sens_q;
   assign common_sens_code_o     = common_sens_q;
   assign idle_sample_interval_o = ctrl_q[touch_key_pkg::INTV_HI:touch_key_pkg::INTV_LO];
   assign immediate_idle_o       = ctrl_q[touch_key_pkg::IMM_BIT];
   assign cal_freeze_o           = ctrl_q[touch_key_pkg::FREEZE_BIT];
   assign undoc_flag_b2_o        = ctrl_q[touch_key_pkg::FLAG_BIT];
   assign undoc_field_b1_0_o     = ctrl_q[touch_key_pkg::FIELD_HI:touch_key_pkg::FIELD_LO];

   touch_idle_ctrl #(
      .NOKEY_CYC  (NOKEY_CYC),
      .HALF_CYC   (HALF_CYC),
      .ACTIVE_CYC (ACTIVE_CYC)
   ) u_idle (
      .core_clk_i    (core_clk_i),
      .rst_i         (rst_i),
      .any_key_i     (any_key),
      .interval_i    (ctrl_q[touch_key_pkg::INTV_HI:touch_key_pkg::INTV_LO]),
      .immediate_i   (ctrl_q[touch_key_pkg::IMM_BIT]),
      .idle_o        (idle_o),
      .sample_tick_o (sample_tick_o)
   );

   // ---------------- Checks ----------------
   AST_START_RESTARTS: assert property (@(posedge link_clk_i) disable iff (rst_i)
      start_det |=> st_q == ST_RX && bit_cnt_q == 4'h0 && idx_q == IDX_ADDR && !sda_oe_q)
      else $error("start did not restart byte reception");

   AST_STOP_RELEASES: assert property (@(posedge link_clk_i) disable iff (rst_i)
      stop_det && !start_det |=> st_q == ST_IDLE && !sda_oe_q)
      else $error("stop did not release the bus");

   AST_SDA_STABLE_HIGH: assert property (@(posedge link_clk_i) disable iff (rst_i)
      scl_s2 && !start_det && !stop_det |=> $stable(sda_oe_q))
      else $error("data line changed while clock high");

   AST_ACK_AFTER_EIGHT: assert property (@(posedge link_clk_i) disable iff (rst_i)
      byte_end && idx_q != IDX_ADDR && !start_det && !stop_det
      |=> sda_oe_q && st_q == ST_ACK)
      else $error("received byte not acknowledged");

   AST_ADDR_MATCH: assert property (@(posedge link_clk_i) disable iff (rst_i)
      byte_end && idx_q == IDX_ADDR && !start_det && !stop_det
      |=> (st_q == ST_ACK) == $past(addr_hit))
      else $error("slave address decode wrong");

   AST_PTR_LOAD: assert property (@(posedge link_clk_i) disable iff (rst_i)
      byte_end && idx_q == IDX_PTR && !start_det && !stop_det |=> ptr_q == $past(sh_q))
      else $error("second byte did not load pointer");

   AST_WRITE_TOGGLE: assert property (@(posedge link_clk_i) disable iff (rst_i)
      byte_end && idx_q == IDX_DATA && !start_det && !stop_det
      |=> wr_tgl_q != $past(wr_tgl_q) && wr_addr_q == $past(ptr_q)
          && ptr_q == $past(ptr_q) + 8'h01)
      else $error("data byte not passed to register file");

   AST_READ_ADVANCE: assert property (@(posedge link_clk_i) disable iff (rst_i)
      st_q == ST_ACK && rd_q && scl_fall && !start_det && !stop_det
      |=> st_q == ST_TX && tx_q == $past(rd_byte) && ptr_q == $past(ptr_q) + 8'h01)
      else $error("read byte or pointer advance wrong");

   AST_UNMAPPED_ZERO: assert property (@(posedge link_clk_i) disable iff (rst_i)
      st_q == ST_ACK && rd_q && scl_fall && !start_det && !stop_det
      && ptr_q != touch_key_pkg::REG_KEY_LOW && ptr_q != touch_key_pkg::REG_KEY_HIGH
      |=> tx_q == touch_key_pkg::READ_ZERO)
      else $error("unmapped read returned nonzero data");

   AST_CTRL_WRITE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      wr_ctrl |=> ctrl_q == $past(wr_data_q)
      ##1 idle_sample_interval_o == ctrl_q[touch_key_pkg::INTV_HI:touch_key_pkg::INTV_LO])
      else $error("control register write lost");

   AST_RO_IGNORED: assert property (@(posedge core_clk_i) disable iff (rst_i)
      wr_pulse && !wr_first && !wr_common && !wr_ctrl
      |=> $stable(first_sens_q) && $stable(common_sens_q) && $stable(ctrl_q))
      else $error("write to unwritable address took effect");

   CVR_CTRL_WRITE: cover property (@(posedge core_clk_i) disable iff (rst_i) wr_ctrl);
   CVR_READ_BYTE: cover property (@(posedge link_clk_i) disable iff (rst_i)
      st_q == ST_RACK && scl_rise && !sda_s2);
   CVR_ADDR_MISS: cover property (@(posedge link_clk_i) disable iff (rst_i)
      byte_end && idx_q == IDX_ADDR && !addr_hit);

endmodule : touch_key_i2c_slave_regs

/* i2c_host_model.sv */
// Behavioural I2C bus master that drives the serial clock and data lines
`timescale 1ns/10ps
module i2c_host_model (
   // Timing reference and resolved data wire
   input  wire logic clk_i,
   input  wire logic sda_i,
   // Open-drain drives, 1 = released to the pull-up
   output logic      scl_o,
   output logic      sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Quarter bit, well above four link clocks
   task automatic half;
      repeat (5) @(negedge clk_i);
   endtask : half
   // Data falls while clock high; also serves as repeated start
   task automatic start;
      half;
      sda_o = 1'b1;
      half;
      scl_o = 1'b1;
      half;
      sda_o = 1'b0;
      half;
      scl_o = 1'b0;
   endtask : start
   task automatic stop;
      half;
      sda_o = 1'b0;
      half;
      scl_o = 1'b1;
      half;
      sda_o = 1'b1;
      half;
   endtask : stop
   // Data set only while clock low, sampled midway through the high phase
   task automatic put_bit(input logic b, output logic r);
      half;
      sda_o = b;
      half;
      scl_o = 1'b1;
      half;
      r = sda_i;
      half;
      scl_o = 1'b0;
   endtask : put_bit
   // Eight bits MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                       output logic ao);
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], q[i]);
      end
      put_bit(ai, ao);
   endtask : xfer
endmodule : i2c_host_model

/* tb_touch_key_i2c_slave_regs.sv */
// Self-checking bench of the touch key I2C slave and register file
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_touch_key_i2c_slave_regs;
   logic        core_clk_i;
   logic        link_clk_i;
   logic        rst_i;
   logic        sel_pin;
   logic        sel_float;
   logic [11:0] keys;
   logic        scl;
   logic        host_sda;
   logic        dev_sda;
   logic        dev_oe;
   wire logic   sda_w;
   logic [7:0]  sens0;
   logic [7:0]  sensc;
   logic [2:0]  intv;
   logic        imm;
   logic        freeze;
   logic        flag;
   logic [1:0]  field;
   logic        idle;
   logic        tick;
   logic [7:0]  ctrl_w;
   int          fail_count = 0;
   int          checks_done = 0;
   int          k;
   logic [6:0]  adr [3] = '{7'h44, 7'h40, 7'h42};
   logic        q_ack;
   logic [7:0]  q_dat;
   // Pull-up on the data wire; the device puts its data value on it while enabled
   assign sda_w  = host_sda & (~dev_oe | dev_sda);
   assign ctrl_w = {intv, imm, freeze, flag, field};
   i2c_host_model u_host (.clk_i(core_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));
   touch_key_i2c_slave_regs #(.NOKEY_CYC(200), .HALF_CYC(20), .ACTIVE_CYC(30)) u_dut (
      .core_clk_i(core_clk_i), .link_clk_i(link_clk_i), .rst_i(rst_i), .scl_i(scl),
      .sda_i(sda_w), .sda_o(dev_sda), .sda_oe_o(dev_oe), .addr_select_pin_i(sel_pin),
      .addr_select_float_i(sel_float), .key_detect_i(keys), .first_chan_sens_code_o(sens0),
      .common_sens_code_o(sensc), .idle_sample_interval_o(intv), .immediate_idle_o(imm),
      .cal_freeze_o(freeze), .undoc_flag_b2_o(flag), .undoc_field_b1_0_o(field),
      .idle_o(idle), .sample_tick_o(tick));
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #3.3;
      forever #7.5 link_clk_i = ~link_clk_i;
   end
   task automatic end_sim;
      if (fail_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic wr(input logic [7:0] b [$]);
      u_host.start();
      foreach (b[i]) begin
         u_host.xfer(b[i], 1'b1, q_dat, q_ack);
         `CHK("write ack", 1'b0, q_ack)
      end
      u_host.stop();
      repeat (20) @(negedge core_clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] e [$]);
      u_host.start();
      u_host.xfer(8'h89, 1'b1, q_dat, q_ack);
      `CHK("read ack", 1'b0, q_ack)
      foreach (e[i]) begin
         u_host.xfer(8'hff, i == e.size() - 1, q_dat, q_ack);
         `CHK("read data", e[i], q_dat)
      end
      u_host.stop();
   endtask : rd
   task automatic wait_idle(input logic e, input int n);
      k = 0;
      while (idle !== e && k < n) begin
         @(negedge core_clk_i);
         k++;
      end
      `CHK("idle", e, idle)
   endtask : wait_idle
   initial begin
      #1_000_000;
      fail_count++;
      end_sim();
   end
   initial begin
      rst_i = 1'b1;
      sel_pin = 1'b1;
      sel_float = 1'b0;
      keys = 12'h201;
      repeat (6) @(negedge core_clk_i);
      rst_i = 1'b0;
      repeat (5) @(negedge core_clk_i);
      `CHK("sens0 reset", 8'h79, sens0)
      `CHK("sensc reset", 8'h79, sensc)
      `CHK("ctrl reset", 8'h83, ctrl_w)
      // Keys 0 and 9 touched read as zero
      rd('{8'h7f, 8'hb0});
      wr('{8'h88, 8'h00, 8'h15, 8'h25, 8'h5a});
      `CHK("sens0", 8'h15, sens0)
      `CHK("sensc", 8'h25, sensc)
      `CHK("ctrl", 8'h5a, ctrl_w)
      `CHK("freeze", 1'b1, freeze)
      // Read-only target, then read across unmapped places
      wr('{8'h88, 8'h08, 8'hff});
      wr('{8'h88, 8'h07});
      rd('{8'h00, 8'h7f, 8'hb0, 8'h00});
      `CHK("sens0 kept", 8'h15, sens0)
      wait_idle(1'b0, 5);
      keys = 12'h000;
      wait_idle(1'b1, 20);
      keys = 12'h001;
      wait_idle(1'b0, 20);
      wr('{8'h88, 8'h02, 8'h83});
      keys = 12'h000;
      repeat (150) @(negedge core_clk_i);
      `CHK("idle early", 1'b0, idle)
      wait_idle(1'b1, 100);
      k = 0;
      while (tick !== 1'b1 && k < 300) begin
         @(negedge core_clk_i);
         k++;
      end
      k = 0;
      do begin
         @(negedge core_clk_i);
         k++;
      end while (tick !== 1'b1 && k < 400);
      `CHK("tick period", 140, k)
      // Interval code 0 stops sampling; longer than any nonzero period
      wr('{8'h88, 8'h02, 8'h1b});
      `CHK("ctrl code 0", 8'h1b, ctrl_w)
      k = 0;
      repeat (400) begin
         @(negedge core_clk_i);
         if (tick !== 1'b0) k++;
      end
      `CHK("ticks code 0", 0, k)
      for (int j = 0; j < 3; j++) begin
         sel_pin = (j == 0);
         sel_float = (j == 1);
         repeat (10) @(negedge core_clk_i);
         u_host.start();
         u_host.xfer({adr[(j + 1) % 3], 1'b0}, 1'b1, q_dat, q_ack);
         `CHK("foreign ack", 1'b1, q_ack)
         u_host.start();
         u_host.xfer({adr[j], 1'b0}, 1'b1, q_dat, q_ack);
         `CHK("own ack", 1'b0, q_ack)
         u_host.stop();
      end
      end_sim();
   end
endmodule : tb_touch_key_i2c_slave_regs
